// >>> codec_checker.sv
// Port-level assertions for the codec port
`timescale 1ns/100ps
`include "serdes_codec_defs.svh"
module codec_checker (
  input wire logic        clk,
  input wire logic        arst_n,
  input wire logic [9:0]  tx_code_ch_a,
  input wire logic [3:0]  tx_code_valid,
  input wire logic [9:0]  rx_code_ch_a,
  input wire logic [3:0]  rx_code_valid,
  input wire logic [9:0]  rx_word_ch_a,
  input wire logic        rx_word_clock_true_ch_a,
  input wire logic        rx_word_clock_comp_ch_a,
  input wire logic        rx_word_clock_true_ch_b,
  input wire logic        rx_word_clock_comp_ch_b,
  input wire logic        rx_word_clock_true_ch_c,
  input wire logic        rx_word_clock_comp_ch_c,
  input wire logic        rx_word_clock_true_ch_d,
  input wire logic        rx_word_clock_comp_ch_d,
  input wire logic [7:0]  bus_addr,
  input wire logic [31:0] bus_wdata,
  input wire logic        bus_wr,
  input wire logic        bus_rd,
  input wire logic [31:0] bus_rdata,
  input wire logic        irq
);
  logic       mode_a_reg;
  logic [3:0] clk_t;
  logic [3:0] clk_c;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  assign clk_t = {rx_word_clock_true_ch_d, rx_word_clock_true_ch_c,
                  rx_word_clock_true_ch_b, rx_word_clock_true_ch_a};
  assign clk_c = {rx_word_clock_comp_ch_d, rx_word_clock_comp_ch_c,
                  rx_word_clock_comp_ch_b, rx_word_clock_comp_ch_a};
  // Channel a mode as software last set it
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      mode_a_reg <= 1'h0;
    end else if (bus_wr && bus_addr == `REG_CTRL) begin
      mode_a_reg <= bus_wdata[0];
    end
  end
  AST_RX_CLK_COMP: assert property (clk_c == ~clk_t)
    else $error("receive clocks not complementary");
  AST_RX_CLK_PULSE: assert property (
    rx_code_valid[0] |=> !rx_word_clock_true_ch_a ##1 rx_word_clock_true_ch_a)
    else $error("receive clock did not mark the word");
  AST_RX_HOLD: assert property (
    !rx_code_valid[0] |=> $stable(rx_word_ch_a))
    else $error("receive word changed without a group");
  AST_RX_RAW: assert property (
    !mode_a_reg && rx_code_valid[0] |=> rx_word_ch_a == $past(rx_code_ch_a))
    else $error("raw receive word differs from group");
  AST_RX_D21: assert property (
    mode_a_reg && rx_code_valid[0] && rx_code_ch_a == 10'h155
    |=> rx_word_ch_a == 10'h0B5)
    else $error("neutral data group decoded wrongly");
  AST_RX_ERR: assert property (
    mode_a_reg && rx_code_valid[0] && rx_code_ch_a == 10'h000
    |=> rx_word_ch_a[9])
    else $error("bad group not flagged");
  AST_TX_PULSE: assert property (
    tx_code_valid[0] |=> !tx_code_valid[0])
    else $error("code valid longer than one cycle");
  AST_TX_HOLD: assert property (
    !tx_code_valid[0] |-> $stable(tx_code_ch_a))
    else $error("transmit code changed without valid");
  AST_RDATA_IDLE: assert property (!bus_rd |=> bus_rdata == 32'h0)
    else $error("read data outside read answer");
  cover property (rx_code_valid[0] && mode_a_reg);
  cover property (tx_code_valid[0]);
  cover property ($rose(irq));
endmodule
bind quad_serdes_parallel_codec_port codec_checker u_chk (
  .clk, .arst_n, .tx_code_ch_a, .tx_code_valid, .rx_code_ch_a,
  .rx_code_valid, .rx_word_ch_a,
  .rx_word_clock_true_ch_a, .rx_word_clock_comp_ch_a,
  .rx_word_clock_true_ch_b, .rx_word_clock_comp_ch_b,
  .rx_word_clock_true_ch_c, .rx_word_clock_comp_ch_c,
  .rx_word_clock_true_ch_d, .rx_word_clock_comp_ch_d,
  .bus_addr, .bus_wdata, .bus_wr, .bus_rd, .bus_rdata, .irq
);

// >>> host_model.sv
// Host-side model driving one channel's transmit word and word clock
`timescale 1ns/100ps
module host_model (
  input  wire logic       clk,
  output logic      [9:0] word,
  output logic            wclk
);
  initial begin
    word = 10'h000;
    wclk = 1'h0;
  end
  task automatic send(input logic [9:0] w);
    @(posedge clk);
    word <= w;
    repeat (4) @(posedge clk);
    wclk <= 1'h1;
    repeat (4) @(posedge clk);
    wclk <= 1'h0;
    // Pins pull low once released
    word <= 10'h000;
  endtask
endmodule

// >>> link_sampler.sv
// Samples one channel's host word clock and word into the core clock
`timescale 1ns/100ps
module link_sampler (
  input  wire logic       clk,
  input  wire logic       arst_n,
  input  wire logic       pin_clk,
  input  wire logic [9:0] pin_word,
  sample_if.src           smp
);
  typedef struct packed {
    logic       clk_s1;
    logic       clk_s2;
    logic       clk_s3;
    logic [9:0] word_s1;
    logic [9:0] word_s2;
    logic [9:0] word_out;
    logic       strobe;
  } sampler_s;

  sampler_s st_reg;
  sampler_s st_next;

  always_comb begin
    st_next         = st_reg;
    st_next.clk_s1  = pin_clk;
    st_next.clk_s2  = st_reg.clk_s1;
    st_next.clk_s3  = st_reg.clk_s2;
    st_next.word_s1 = pin_word;
    st_next.word_s2 = st_reg.word_s1;
    st_next.strobe  = 1'b0;
    // Word taken on its own clock's rise
    if (st_reg.clk_s2 && !st_reg.clk_s3) begin
      st_next.word_out = st_reg.word_s2;
      st_next.strobe   = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign smp.word   = st_reg.word_out;
  assign smp.strobe = st_reg.strobe;
endmodule

// >>> quad_serdes_parallel_codec_port.sv
// Four-channel parallel word port with 8b/10b encoder and decoder
//
// Design decisions made here: the register offsets and the strobed register port.
`timescale 1ns/100ps
`include "serdes_codec_defs.svh"
module quad_serdes_parallel_codec_port (
  input  wire logic        clk,
  input  wire logic        arst_n,
  input  wire logic [9:0]  tx_word_ch_a,
  input  wire logic [9:0]  tx_word_ch_b,
  input  wire logic [9:0]  tx_word_ch_c,
  input  wire logic [9:0]  tx_word_ch_d,
  input  wire logic        tx_word_clock_ch_a,
  input  wire logic        tx_word_clock_ch_b,
  input  wire logic        tx_word_clock_ch_c,
  input  wire logic        tx_word_clock_ch_d,
  output logic      [9:0]  tx_code_ch_a,
  output logic      [9:0]  tx_code_ch_b,
  output logic      [9:0]  tx_code_ch_c,
  output logic      [9:0]  tx_code_ch_d,
  output logic      [3:0]  tx_code_valid,
  input  wire logic [9:0]  rx_code_ch_a,
  input  wire logic [9:0]  rx_code_ch_b,
  input  wire logic [9:0]  rx_code_ch_c,
  input  wire logic [9:0]  rx_code_ch_d,
  input  wire logic [3:0]  rx_code_valid,
  output logic      [9:0]  rx_word_ch_a,
  output logic      [9:0]  rx_word_ch_b,
  output logic      [9:0]  rx_word_ch_c,
  output logic      [9:0]  rx_word_ch_d,
  output logic             rx_word_clock_true_ch_a,
  output logic             rx_word_clock_comp_ch_a,
  output logic             rx_word_clock_true_ch_b,
  output logic             rx_word_clock_comp_ch_b,
  output logic             rx_word_clock_true_ch_c,
  output logic             rx_word_clock_comp_ch_c,
  output logic             rx_word_clock_true_ch_d,
  output logic             rx_word_clock_comp_ch_d,
  input  wire logic [7:0]  bus_addr,
  input  wire logic [31:0] bus_wdata,
  input  wire logic        bus_wr,
  input  wire logic        bus_rd,
  output logic      [31:0] bus_rdata,
  output logic             irq
);
  typedef struct packed {
    logic [`NUM_CH-1:0]       mode8;
    logic [7:0]               status;
    logic [7:0]               mask;
    logic [`NUM_CH-1:0]       tx_rd;
    logic [`NUM_CH-1:0]       rx_rd;
    logic [`NUM_CH-1:0][9:0]  tx_code;
    logic [`NUM_CH-1:0]       tx_valid;
    logic [`NUM_CH-1:0][9:0]  rx_word;
    logic [`NUM_CH-1:0]       rxc_true;
    logic [`NUM_CH-1:0]       rxc_comp;
    logic [31:0]              rdata;
    logic                     irq;
  } port_s;

  port_s st_reg;
  port_s st_next;

  logic [`NUM_CH-1:0][9:0] tx_pin_word;
  logic [`NUM_CH-1:0]      tx_pin_clk;
  logic [`NUM_CH-1:0][9:0] rx_code;
  logic [`NUM_CH-1:0][9:0] smp_word;
  logic [`NUM_CH-1:0]      smp_strobe;

  assign tx_pin_word = {tx_word_ch_d, tx_word_ch_c,
                        tx_word_ch_b, tx_word_ch_a};
  assign tx_pin_clk  = {tx_word_clock_ch_d, tx_word_clock_ch_c,
                        tx_word_clock_ch_b, tx_word_clock_ch_a};
  assign rx_code     = {rx_code_ch_d, rx_code_ch_c,
                        rx_code_ch_b, rx_code_ch_a};

  for (genvar gi = 0; gi < `NUM_CH; gi++) begin : g_ch
    sample_if smp ();
    link_sampler u_smp (
      .clk      (clk),
      .arst_n   (arst_n),
      .pin_clk  (tx_pin_clk[gi]),
      .pin_word (tx_pin_word[gi]),
      .smp      (smp.src)
    );
    assign smp_word[gi]   = smp.word;
    assign smp_strobe[gi] = smp.strobe;
  end

  function automatic logic [3:0] ones(input logic [9:0] v);
    logic [3:0] n;
    n = 4'h0;
    for (int i = 0; i < 10; i++) begin
      n = n + {3'h0, v[i]};
    end
    return n;
  endfunction

  // Transmit order a..j maps to bit 0..9
  function automatic logic [9:0] rev10(input logic [9:0] v);
    logic [9:0] r;
    for (int i = 0; i < 10; i++) begin
      r[i] = v[9-i];
    end
    return r;
  endfunction

  function automatic logic [5:0] enc6(input logic [4:0] x,
                                      input logic       rd);
    logic [5:0] c;
    case (x)
      5'h00: c = 6'h27;
      5'h01: c = 6'h1D;
      5'h02: c = 6'h2D;
      5'h03: c = 6'h31;
      5'h04: c = 6'h35;
      5'h05: c = 6'h29;
      5'h06: c = 6'h19;
      5'h07: c = 6'h38;
      5'h08: c = 6'h39;
      5'h09: c = 6'h25;
      5'h0A: c = 6'h15;
      5'h0B: c = 6'h34;
      5'h0C: c = 6'h0D;
      5'h0D: c = 6'h2C;
      5'h0E: c = 6'h1C;
      5'h0F: c = 6'h17;
      5'h10: c = 6'h1B;
      5'h11: c = 6'h23;
      5'h12: c = 6'h13;
      5'h13: c = 6'h32;
      5'h14: c = 6'h0B;
      5'h15: c = 6'h2A;
      5'h16: c = 6'h1A;
      5'h17: c = 6'h3A;
      5'h18: c = 6'h33;
      5'h19: c = 6'h26;
      5'h1A: c = 6'h16;
      5'h1B: c = 6'h36;
      5'h1C: c = 6'h0E;
      5'h1D: c = 6'h2E;
      5'h1E: c = 6'h1E;
      default: c = 6'h2B;
    endcase
    if (rd && (ones({4'h0, c}) != 4'h3 || x == 5'h07)) begin
      c = ~c;
    end
    return c;
  endfunction

  // Four-bit groups, alt selects the A7 form
  function automatic logic [3:0] enc4(input logic [2:0] y,
                                      input logic       rd,
                                      input logic       alt);
    logic [3:0] c;
    case (y)
      3'h0: c = 4'hB;
      3'h1: c = 4'h9;
      3'h2: c = 4'h5;
      3'h3: c = 4'hC;
      3'h4: c = 4'hD;
      3'h5: c = 4'hA;
      3'h6: c = 4'h6;
      default: c = alt ? `A7_4B : 4'hE;
    endcase
    if (rd && (ones({6'h00, c}) != 4'h2 || y == 3'h3)) begin
      c = ~c;
    end
    return c;
  endfunction

  function automatic logic nrd(input logic [9:0] w, input logic rd);
    logic r;
    r = rd;
    if (ones(w) == 4'h6) begin
      r = 1'b1;
    end else if (ones(w) == 4'h4) begin
      r = 1'b0;
    end
    return r;
  endfunction

  function automatic logic kx7(input logic [4:0] x);
    return x == 5'h17 || x == 5'h1B || x == 5'h1D || x == 5'h1E;
  endfunction

  function automatic logic [9:0] enc10(input logic [7:0] b,
                                       input logic       k,
                                       input logic       rd);
    logic [4:0] x;
    logic [2:0] y;
    logic [5:0] c6;
    logic [3:0] c4;
    logic       rd6;
    logic       alt;
    x = b[4:0];
    y = b[7:5];
    // K28 control group when the select bit is high
    if (k && x == `K28_X) begin
      c6 = rd ? ~`K28_6B : `K28_6B;
      // K28.7 takes the alternate four-bit form
      c4 = rd ? ~enc4(y, 1'b1, y == 3'h7) : enc4(y, 1'b1, y == 3'h7);
    end else begin
      c6  = enc6(x, rd);
      rd6 = (ones({4'h0, c6}) == 4'h3) ? rd : ~rd;
      alt = (k && kx7(x)) ||
            (!rd6 && (x == 5'h11 || x == 5'h12 || x == 5'h14)) ||
            (rd6 && (x == 5'h0B || x == 5'h0D || x == 5'h0E));
      c4  = enc4(y, rd6, alt);
    end
    return rev10({c6, c4});
  endfunction

  // Code group to {error, control, byte}
  function automatic logic [9:0] dec10(input logic [9:0] w,
                                       input logic       rd);
    logic [9:0] r;
    logic [5:0] c6;
    logic [3:0] c4;
    logic       rd6;
    logic       hit6;
    logic       hit4;
    logic       k28;
    logic       k;
    logic [4:0] x;
    logic [2:0] y;
    r    = rev10(w);
    c6   = r[9:4];
    c4   = r[3:0];
    hit6 = 1'b0;
    hit4 = 1'b0;
    x    = 5'h00;
    y    = 3'h0;
    k28  = c6 == (rd ? ~`K28_6B : `K28_6B);
    k    = k28;
    for (int i = 0; i < 32; i++) begin
      if (enc6(5'(i), rd) == c6) begin
        hit6 = 1'b1;
        x    = 5'(i);
      end
    end
    if (k28) begin
      hit6 = 1'b1;
      x    = `K28_X;
    end
    rd6 = (ones({4'h0, c6}) == 4'h3) ? rd : ~rd;
    for (int j = 0; j < 8; j++) begin
      if (k28) begin
        if (c4 == (rd ? ~enc4(3'(j), 1'b1, 3'(j) == 3'h7)
                      : enc4(3'(j), 1'b1, 3'(j) == 3'h7))) begin
          hit4 = 1'b1;
          y    = 3'(j);
        end
      end else if (enc4(3'(j), rd6, 1'b0) == c4) begin
        hit4 = 1'b1;
        y    = 3'(j);
      end
    end
    if (!k28 && c4 == enc4(3'h7, rd6, 1'b1)) begin
      hit4 = 1'b1;
      y    = 3'h7;
      k    = kx7(x);
    end
    return {!(hit6 && hit4), k, y, x};
  endfunction

  always_comb begin
    logic [7:0]               events;
    logic [7:0]               clr;
    logic [9:0]               d;
    serdes_codec_pkg::word_mode_e m;
    events           = 8'h00;
    clr              = 8'h00;
    d                = 10'h000;
    m                = serdes_codec_pkg::MODE_10BIT;
    st_next          = st_reg;
    st_next.tx_valid = '0;
    st_next.rdata    = 32'h0000_0000;

    for (int c = 0; c < `NUM_CH; c++) begin
      // One mode bit steers both paths
      m = serdes_codec_pkg::word_mode_e'(st_reg.mode8[c]);
      if (smp_strobe[c]) begin
        st_next.tx_valid[c] = 1'b1;
        case (m)
          serdes_codec_pkg::MODE_8BIT: begin
            // Encode low byte, running disparity kept
            st_next.tx_code[c] = enc10(smp_word[c][7:0],
                                       smp_word[c][8],
                                       st_reg.tx_rd[c]);
            st_next.tx_rd[c]   = nrd(st_next.tx_code[c],
                                     st_reg.tx_rd[c]);
          end
          default: begin
            st_next.tx_code[c] = smp_word[c];
          end
        endcase
      end

      // True clock rises a cycle after data
      st_next.rxc_true[c] = 1'b1;
      st_next.rxc_comp[c] = 1'b0;
      if (rx_code_valid[c]) begin
        st_next.rxc_true[c] = 1'b0;
        st_next.rxc_comp[c] = 1'b1;
        case (m)
          serdes_codec_pkg::MODE_8BIT: begin
            d                   = dec10(rx_code[c], st_reg.rx_rd[c]);
            st_next.rx_word[c]  = d;
            st_next.rx_rd[c]    = nrd(rx_code[c], st_reg.rx_rd[c]);
            events[`ST_ERR_LSB + c] = d[9];
            events[`ST_K_LSB + c]   = d[8];
          end
          default: begin
            st_next.rx_word[c] = rx_code[c];
          end
        endcase
      end
    end

    if (bus_wr) begin
      case (bus_addr)
        `REG_CTRL:   st_next.mode8 = bus_wdata[`NUM_CH-1:0];
        `REG_STATUS: clr = bus_wdata[7:0];
        `REG_MASK:   st_next.mask = bus_wdata[7:0];
        default:     clr = 8'h00;
      endcase
    end
    // New events beat a same-cycle clear
    st_next.status = (st_reg.status & ~clr) | events;
    st_next.irq    = |(st_next.status & st_next.mask);

    if (bus_rd) begin
      case (bus_addr)
        `REG_CTRL:   st_next.rdata = {28'h0, st_reg.mode8};
        `REG_STATUS: st_next.rdata = {24'h0, st_reg.status};
        `REG_MASK:   st_next.rdata = {24'h0, st_reg.mask};
        `REG_DISP:   st_next.rdata = {24'h0, st_reg.rx_rd, st_reg.tx_rd};
        default:     st_next.rdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      st_reg          <= '0;
      st_reg.rxc_comp <= '1;
    end else begin
      st_reg <= st_next;
    end
  end

  assign tx_code_ch_a            = st_reg.tx_code[0];
  assign tx_code_ch_b            = st_reg.tx_code[1];
  assign tx_code_ch_c            = st_reg.tx_code[2];
  assign tx_code_ch_d            = st_reg.tx_code[3];
  assign tx_code_valid           = st_reg.tx_valid;
  assign rx_word_ch_a            = st_reg.rx_word[0];
  assign rx_word_ch_b            = st_reg.rx_word[1];
  assign rx_word_ch_c            = st_reg.rx_word[2];
  assign rx_word_ch_d            = st_reg.rx_word[3];
  assign rx_word_clock_true_ch_a = st_reg.rxc_true[0];
  assign rx_word_clock_comp_ch_a = st_reg.rxc_comp[0];
  assign rx_word_clock_true_ch_b = st_reg.rxc_true[1];
  assign rx_word_clock_comp_ch_b = st_reg.rxc_comp[1];
  assign rx_word_clock_true_ch_c = st_reg.rxc_true[2];
  assign rx_word_clock_comp_ch_c = st_reg.rxc_comp[2];
  assign rx_word_clock_true_ch_d = st_reg.rxc_true[3];
  assign rx_word_clock_comp_ch_d = st_reg.rxc_comp[3];
  assign bus_rdata               = st_reg.rdata;
  assign irq                     = st_reg.irq;
endmodule

// >>> sample_if.sv
// Synchronised transmit word and its capture strobe
`timescale 1ns/100ps
interface sample_if;
  serdes_codec_pkg::code_t word;
  logic                    strobe;
  modport src (output word, output strobe);
  modport dst (input word, input strobe);
endinterface

// >>> serdes_codec_defs.svh
// Register map, field positions and code constants of the codec port
// Function
// - 10-bit mode: word passes unchanged, bit 9 MSB
// - 8-bit mode: bits 7..0 encoded 8b/10b
// - Word bit 8 selects data or control group
// - Four identical independent channels, ten-bit words
// - 10-bit mode: received group shown undecoded
// - 8-bit mode: decoded byte on bits 7..0
// - 8-bit mode: bit 9 flags decode error
// - 8-bit mode: bit 8 flags control character
// - Code tables follow the standard gigabit set
// - Complementary receive word clocks per channel
`ifndef SERDES_CODEC_DEFS_SVH
`define SERDES_CODEC_DEFS_SVH
`define NUM_CH      4
`define REG_CTRL    8'h00
`define REG_STATUS  8'h04
`define REG_MASK    8'h08
`define REG_DISP    8'h0C
`define ST_ERR_LSB  0
`define ST_K_LSB    4
`define DISP_RX_LSB 4
`define K28_6B      6'h0F
`define K28_X       5'h1C
`define A7_4B       4'h7
`endif

// >>> serdes_codec_pkg.sv
// Types shared by the codec port modules
package serdes_codec_pkg;
  typedef logic [9:0] code_t;
  typedef enum logic {MODE_10BIT, MODE_8BIT} word_mode_e;
endpackage

// >>> tb.sv
// Self-checking bench for the four-channel codec port
`timescale 1ns/100ps
`include "serdes_codec_defs.svh"
module tb;
  logic        clk, arst_n, bus_wr, bus_rd, irq;
  logic [9:0]  tx_word_ch_a, tx_word_ch_b, tx_word_ch_c, tx_word_ch_d;
  logic        tx_word_clock_ch_a, tx_word_clock_ch_b;
  logic        tx_word_clock_ch_c, tx_word_clock_ch_d;
  logic [9:0]  tx_code_ch_a, tx_code_ch_b, tx_code_ch_c, tx_code_ch_d;
  logic [9:0]  rx_code_ch_a, rx_code_ch_b, rx_code_ch_c, rx_code_ch_d;
  logic [9:0]  rx_word_ch_a, rx_word_ch_b, rx_word_ch_c, rx_word_ch_d;
  logic [3:0]  tx_code_valid, rx_code_valid;
  logic        rx_word_clock_true_ch_a, rx_word_clock_comp_ch_a;
  logic        rx_word_clock_true_ch_b, rx_word_clock_comp_ch_b;
  logic        rx_word_clock_true_ch_c, rx_word_clock_comp_ch_c;
  logic        rx_word_clock_true_ch_d, rx_word_clock_comp_ch_d;
  logic [7:0]  bus_addr;
  logic [31:0] bus_wdata, bus_rdata, d;
  int          err_count = 0, num_checks = 0, cyc = 0;
  typedef struct {logic md; logic [9:0] txw, txe, rxc, rxe;} row_s;
  // Encoder starts from negative disparity; 10-bit row last
  row_s rows [6] = '{
    '{1'h1, 10'h1BC, 10'h17C, 10'h17C, 10'h1BC},
    '{1'h1, 10'h1BC, 10'h283, 10'h283, 10'h1BC},
    '{1'h1, 10'h2B5, 10'h155, 10'h155, 10'h0B5},
    '{1'h1, 10'h000, 10'h0B9, 10'h0B9, 10'h000},
    '{1'h1, 10'h1FC, 10'h07C, 10'h07C, 10'h1FC},
    '{1'h0, 10'h2A5, 10'h2A5, 10'h15A, 10'h15A}
  };
  host_model host_a (.clk, .word(tx_word_ch_a), .wclk(tx_word_clock_ch_a));
  host_model host_b (.clk, .word(tx_word_ch_b), .wclk(tx_word_clock_ch_b));
  host_model host_c (.clk, .word(tx_word_ch_c), .wclk(tx_word_clock_ch_c));
  host_model host_d (.clk, .word(tx_word_ch_d), .wclk(tx_word_clock_ch_d));
  quad_serdes_parallel_codec_port dut (.*);
  initial begin
    clk = 1'h0;
    forever #50 clk = ~clk;
  end
  task automatic chk(input string n, input logic [39:0] e, g);
    num_checks++;
    if (g !== e) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk);
    bus_addr <= a;
    bus_wdata <= v;
    bus_wr <= 1'h1;
    @(posedge clk);
    bus_wr <= 1'h0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge clk);
    bus_addr <= a;
    bus_rd <= 1'h1;
    @(posedge clk);
    bus_rd <= 1'h0;
    #1 v = bus_rdata;
  endtask
  task automatic rxs(input logic [39:0] c, input logic [3:0] v);
    @(posedge clk);
    {rx_code_ch_d, rx_code_ch_c, rx_code_ch_b, rx_code_ch_a} <= c;
    rx_code_valid <= v;
    @(posedge clk);
    rx_code_valid <= 4'h0;
    {rx_code_ch_d, rx_code_ch_c, rx_code_ch_b, rx_code_ch_a} <= ~c;
    #1;
  endtask
  task automatic finish_test;
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      finish_test;
    end
  end
  initial begin
    arst_n = 1'h0;
    bus_wr = 1'h0;
    bus_rd = 1'h0;
    bus_addr = 8'h00;
    bus_wdata = 32'h0;
    rx_code_valid = 4'h0;
    {rx_code_ch_d, rx_code_ch_c, rx_code_ch_b, rx_code_ch_a} = 40'h0;
    repeat (10) @(posedge clk);
    arst_n <= 1'h1;
    repeat (3) @(posedge clk);
    foreach (rows[i]) begin
      wr(`REG_CTRL, {28'h0, {4{rows[i].md}}});
      host_a.send(rows[i].txw);
      repeat (2) @(posedge clk);
      #1;
      chk("tx code", rows[i].txe, tx_code_ch_a);
      rxs({30'h0, rows[i].rxc}, 4'h1);
      chk("rx word", rows[i].rxe, rx_word_ch_a);
    end
    rd(`REG_STATUS, d);
    chk("status", 32'h10, d);
    // Bad group: error bit, sticky status, irq only when unmasked
    wr(`REG_CTRL, 32'h0000000F);
    rxs(40'h0, 4'h1);
    chk("rx error", 40'h1, rx_word_ch_a[9]);
    rd(`REG_STATUS, d);
    chk("status err", 32'h1, d & 32'h0F);
    chk("irq masked", 40'h0, irq);
    wr(`REG_MASK, 32'h1);
    @(posedge clk);
    #1;
    chk("irq", 40'h1, irq);
    wr(`REG_STATUS, 32'h1);
    @(posedge clk);
    #1;
    chk("irq cleared", 40'h0, irq);
    // Mode per channel, both paths, channels apart
    wr(`REG_CTRL, 32'h00000002);
    fork
      host_a.send(10'h3C1);
      host_b.send(10'h0B5);
      host_c.send(10'h2A5);
      host_d.send(10'h11E);
    join
    repeat (2) @(posedge clk);
    #1;
    chk("tx codes", {10'h11E, 10'h2A5, 10'h155, 10'h3C1},
        {tx_code_ch_d, tx_code_ch_c, tx_code_ch_b, tx_code_ch_a});
    rxs({10'h11E, 10'h2A5, 10'h155, 10'h3C1}, 4'hF);
    chk("rx words", {10'h11E, 10'h2A5, 10'h0B5, 10'h3C1},
        {rx_word_ch_d, rx_word_ch_c, rx_word_ch_b, rx_word_ch_a});
    // Mid-run reset, then all registers and the holes up to 0x40 read zero
    @(posedge clk);
    arst_n <= 1'h0;
    @(posedge clk);
    #1;
    chk("clocks in reset", 40'h1,
        {rx_word_ch_a, rx_word_clock_true_ch_a, rx_word_clock_comp_ch_a});
    repeat (10) @(posedge clk);
    arst_n <= 1'h1;
    repeat (3) @(posedge clk);
    for (int a = 0; a <= 8'h40; a += 4) begin
      rd(8'(a), d);
      chk("register after reset", 40'h0, d);
    end
    finish_test;
  end
endmodule
